// ===== adcrp_pkg.sv
/*
 * Package for the converter result and prescaler block: register offsets,
 * divider codes, reset values and the bus carrier structs.
 * Assumes an 8-bit I/O register bus driven by the processor core.
 */
package adcrp_pkg;
	// I/O offsets of the result pair and the data-space displacement
	localparam logic [7:0] ADCRP_OFS_RESULT_LOW = 8'h04;
	localparam logic [7:0] ADCRP_OFS_RESULT_HIGH = 8'h05;
	localparam logic [7:0] ADCRP_DATA_SPACE_OFS = 8'h20;
	localparam logic [7:0] ADCRP_RESET_BYTE = 8'h00;
	// Result width and divider width
	localparam int ADCRP_RES_W = 10;
	localparam int ADCRP_DIV_W = 7;
	localparam logic [6:0] ADCRP_DIV_ZERO = 7'h00;
	// Divide select codes
	localparam logic [2:0] ADCRP_DIV2_A = 3'h0;
	localparam logic [2:0] ADCRP_DIV2_B = 3'h1;
	localparam logic [2:0] ADCRP_DIV4 = 3'h2;
	localparam logic [2:0] ADCRP_DIV8 = 3'h3;
	localparam logic [2:0] ADCRP_DIV16 = 3'h4;
	localparam logic [2:0] ADCRP_DIV32 = 3'h5;
	localparam logic [2:0] ADCRP_DIV64 = 3'h6;
	localparam logic [2:0] ADCRP_DIV128 = 3'h7;
	// Half-period terminal counts (divide factor / 2 - 1)
	localparam logic [6:0] ADCRP_HALF2 = 7'h00;
	localparam logic [6:0] ADCRP_HALF4 = 7'h01;
	localparam logic [6:0] ADCRP_HALF8 = 7'h03;
	localparam logic [6:0] ADCRP_HALF16 = 7'h07;
	localparam logic [6:0] ADCRP_HALF32 = 7'h0f;
	localparam logic [6:0] ADCRP_HALF64 = 7'h1f;
	localparam logic [6:0] ADCRP_HALF128 = 7'h3f;

	// Read request from the core
	typedef struct packed {
		logic rd;
		logic data_space;
		logic [7:0] addr;
	} adcrp_req_s;

	// Finished conversion from the analog side
	typedef struct packed {
		logic done;
		logic differential;
		logic [9:0] value;
	} adcrp_conv_s;
endpackage : adcrp_pkg

// ===== adcrp_prescaler.sv
/*
 * Converter clock prescaler: divides the system clock by 2..128.
 * Assumes the select code comes from logic on the same clock.
 */
`timescale 1ns/10ps
module adcrp_prescaler (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic [2:0] clock_divide_select,
	// Converter clock, straight from a flip-flop
	output logic conv_clk
);
	import adcrp_pkg::*;

	logic [6:0] count;
	logic [6:0] next_count;
	logic next_conv_clk;
	logic [6:0] half;

	// Map a select code to its half-period terminal count
	function automatic logic [6:0] half_count(input logic [2:0] sel);
		case (sel)
			ADCRP_DIV2_A, ADCRP_DIV2_B: half_count = ADCRP_HALF2; // [RQ1]
			ADCRP_DIV4: half_count = ADCRP_HALF4;
			ADCRP_DIV8: half_count = ADCRP_HALF8;
			ADCRP_DIV16: half_count = ADCRP_HALF16;
			ADCRP_DIV32: half_count = ADCRP_HALF32;
			ADCRP_DIV64: half_count = ADCRP_HALF64;
			default: half_count = ADCRP_HALF128;
		endcase
	endfunction : half_count

	// Toggle the output every half period; a shrinking code restarts cleanly
	always_comb begin
		half = half_count(clock_divide_select);
		next_count = count + 7'h01;
		next_conv_clk = conv_clk;
		if (count >= half) begin // [RQ12]
			next_count = ADCRP_DIV_ZERO;
			next_conv_clk = ~conv_clk;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			count <= ADCRP_DIV_ZERO;
			conv_clk <= 1'b0;
		end else begin
			count <= next_count;
			conv_clk <= next_conv_clk;
		end
	end

	// Output period equals the selected factor
	a_div_toggle: assert property (@(posedge mclk) disable iff (rst) // [RQ1]
		(!$stable(conv_clk) && $stable(clock_divide_select) && clock_divide_select <= ADCRP_DIV2_B)
		|=> !$stable(conv_clk)) else $error("divide-by-2 output did not toggle");
	a_div_hold: assert property (@(posedge mclk) disable iff (rst) // [RQ12]
		(!$stable(conv_clk) && clock_divide_select == ADCRP_DIV4 && $stable(clock_divide_select))
		|=> $stable(conv_clk) ##1 !$stable(conv_clk)) else $error("divide-by-4 timing wrong");
	c_div128: cover property (@(posedge mclk) clock_divide_select == ADCRP_DIV128 && !$stable(conv_clk));
endmodule : adcrp_prescaler

// ===== adcrp_top.sv
/*
 * Converter result registers and prescaler control.
 * Assumes the core reads with a one-cycle rd pulse and takes data next cycle;
 * conversion results arrive from logic on mclk.
 */
// Overview of operation
// (RQ1) Divide select codes 000/001 give /2, then /4 up to /128.
// (RQ2) A finished conversion loads the low and high result bytes.
// (RQ3) Differential results are delivered as two's complement values.
// (RQ4) Reading the low byte freezes both bytes until the high byte is read; a result done in the low read's cycle still loads.
// (RQ5) Software reads low then high; high alone is fine left adjusted.
// (RQ6) Left adjust select set gives left alignment, clear gives right.
// (RQ7) Right adjusted: low holds bits 7:0, high bits 1:0 hold 9:8.
// (RQ8) Left adjusted: high holds bits 9:2, low bits 7:6 hold 1:0.
// (RQ9) Both bytes are read-only at offsets 0x04 and 0x05, reset zero.
// (RQ10) Data-space accesses reach them at 0x24 and 0x25.
// (RQ11) Changing left adjust select realigns the visible bytes at once.
// (RQ12) Prescaler divides the system clock to make the converter clock.
// (RQ13) A result finishing during a held read is discarded.
`timescale 1ns/10ps
module adcrp_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// I/O register read port
	input adcrp_pkg::adcrp_req_s req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Control bits from the control registers
	input wire logic left_adjust_select,
	input wire logic [2:0] clock_divide_select,
	// Converter side
	input adcrp_pkg::adcrp_conv_s conv,
	output logic conv_clk,
	output logic result_held
);
	import adcrp_pkg::*;

	typedef enum logic [0:0] {ADCRP_OPEN, ADCRP_HELD} adcrp_state_e;

	adcrp_state_e state;
	adcrp_state_e next_state;
	logic [9:0] result;
	logic [9:0] next_result;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic next_result_held;
	logic sel_low;
	logic sel_high;

	// Hit test for one register at either its I/O or data-space address
	function automatic logic addr_hit(input logic [7:0] addr, input logic dspace, input logic [7:0] ofs);
		addr_hit = dspace ? (addr == ofs + ADCRP_DATA_SPACE_OFS) : (addr == ofs); // [RQ10]
	endfunction : addr_hit

	// Byte presentation: realigned combinationally from the stored result
	function automatic logic [7:0] view(input logic [9:0] r, input logic left, input logic high);
		logic [7:0] v;
		v = ADCRP_RESET_BYTE;
		if (left) begin // [RQ6] [RQ11]
			v = high ? r[9:2] : {r[1:0], 6'h00}; // [RQ8]
		end else begin
			v = high ? {6'h00, r[9:8]} : r[7:0]; // [RQ7]
		end
		view = v;
	endfunction : view

	adcrp_prescaler u_prescaler (
		.mclk(mclk),
		.rst(rst),
		.clock_divide_select(clock_divide_select),
		.conv_clk(conv_clk)
	);

	// Address decode, shared by the hold group and the read group; a data-space
	// access at a bare I/O offset is not a hit
	always_comb begin
		sel_low = req.rd && addr_hit(req.addr, req.data_space, ADCRP_OFS_RESULT_LOW); // [RQ10]
		sel_high = req.rd && addr_hit(req.addr, req.data_space, ADCRP_OFS_RESULT_HIGH); // [RQ10]
	end

	// Hold group: the value is the converter's own two's complement code for
	// differential pairs, so it is stored unmodified
	always_comb begin
		next_state = state;
		next_result = result;
		case (state)
			ADCRP_OPEN: begin
				if (conv.done) begin
					next_result = conv.value; // [RQ2] [RQ3]
				end
				if (sel_low) begin
					next_state = ADCRP_HELD; // [RQ4]
				end
			end
			ADCRP_HELD: begin
				// New results are dropped while held; one landing with the low read itself still loads
				// and tears the pair, and one landing with the releasing high read is lost as well
				if (sel_high) begin // [RQ13]
					next_state = ADCRP_OPEN;
				end
			end
			default: next_state = ADCRP_OPEN;
		endcase
		next_result_held = (next_state == ADCRP_HELD);
	end

	// Hold group registers; reset clears the stored pair to zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ADCRP_OPEN;
			result <= {ADCRP_RESET_BYTE[1:0], ADCRP_RESET_BYTE}; // [RQ9]
			result_held <= 1'b0;
		end else begin
			state <= next_state;
			result <= next_result;
			result_held <= next_result_held;
		end
	end

	// Read group: data comes from the value visible in the read cycle, so an
	// alignment change shows on the very next read with no reload
	always_comb begin
		next_rvalid = req.rd;
		next_rdata = ADCRP_RESET_BYTE;
		if (sel_low) begin // [RQ9]
			next_rdata = view(result, left_adjust_select, 1'b0);
		end else if (sel_high) begin
			next_rdata = view(result, left_adjust_select, 1'b1);
		end
	end

	// Read group registers; unmapped reads still answer, with zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= ADCRP_RESET_BYTE;
			rvalid <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// Checks below watch only what this block drives; stimulus legality is the
	// partner's business. Each antecedent is reached by the standard read and
	// conversion sequences, so none of them holds vacuously.
	// Hold and release of the pair
	a_held_stable: assert property (@(posedge mclk) disable iff (rst) // [RQ4] [RQ13]
		(state == ADCRP_HELD && !sel_high) |=> $stable(result))
		else $error("held result changed");
	a_low_freezes: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
		(state == ADCRP_OPEN && sel_low) |=> result_held)
		else $error("low read did not hold");
	a_high_release: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
		(state == ADCRP_HELD && sel_high) |=> !result_held)
		else $error("high read did not release");
	a_held_level: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
		result_held == (state == ADCRP_HELD))
		else $error("held flag disagrees with state");
	a_high_open: assert property (@(posedge mclk) disable iff (rst) // [RQ4]
		(state == ADCRP_OPEN && sel_high) |=> !result_held)
		else $error("lone high read held the pair");

	// Loading and dropping of new results
	a_load_done: assert property (@(posedge mclk) disable iff (rst) // [RQ2] [RQ3]
		(state == ADCRP_OPEN && conv.done) |=> result == $past(conv.value))
		else $error("result not loaded");
	a_open_tracks: assert property (@(posedge mclk) disable iff (rst) // [RQ2]
		(state == ADCRP_OPEN && !conv.done) |=> $stable(result))
		else $error("result changed without a conversion");
	a_drop_held: assert property (@(posedge mclk) disable iff (rst) // [RQ13]
		(state == ADCRP_HELD && conv.done) |=> $stable(result))
		else $error("held result overwritten");

	// Byte views in both alignments
	a_right_low: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
		(sel_low && !left_adjust_select) |=> rvalid && rdata == $past(result[7:0]))
		else $error("right low wrong");
	a_right_high: assert property (@(posedge mclk) disable iff (rst) // [RQ7]
		(sel_high && !left_adjust_select) |=> rdata == {6'h00, $past(result[9:8])})
		else $error("right high wrong");
	a_left_high: assert property (@(posedge mclk) disable iff (rst) // [RQ8] [RQ11]
		(sel_high && left_adjust_select) |=> rdata == $past(result[9:2]))
		else $error("left high wrong");
	a_left_low: assert property (@(posedge mclk) disable iff (rst) // [RQ8]
		(sel_low && left_adjust_select) |=> rdata == {$past(result[1:0]), 6'h00})
		else $error("left low wrong");

	// Decode and answer of the read port
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst) // [RQ9] [RQ10]
		(req.rd && !sel_low && !sel_high) |=> rdata == ADCRP_RESET_BYTE)
		else $error("unmapped read nonzero");
	a_rvalid_follows: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
		req.rd |=> rvalid)
		else $error("read not answered");
	a_idle_quiet: assert property (@(posedge mclk) disable iff (rst) // [RQ9]
		!req.rd |=> !rvalid && rdata == ADCRP_RESET_BYTE)
		else $error("answer without read");
	a_data_low_hit: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
		(req.rd && req.data_space && req.addr == ADCRP_OFS_RESULT_LOW + ADCRP_DATA_SPACE_OFS) |-> sel_low)
		else $error("data-space low address missed");
	a_io_high_hit: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
		(req.rd && !req.data_space && req.addr == ADCRP_OFS_RESULT_HIGH) |-> sel_high)
		else $error("io high address missed");
	a_space_split: assert property (@(posedge mclk) disable iff (rst) // [RQ10]
		(req.rd && req.data_space && req.addr == ADCRP_OFS_RESULT_LOW) |-> !sel_low)
		else $error("data-space read hit an io offset");

	// Reset empties the pair and silences the read port; checked without the
	// usual disable so the reset cycles themselves are covered
	a_reset_clear: assert property (@(posedge mclk) // [RQ9]
		rst |=> !rvalid && !result_held && rdata == ADCRP_RESET_BYTE
			&& result == {ADCRP_RESET_BYTE[1:0], ADCRP_RESET_BYTE})
		else $error("reset left state behind");

	// Main scenarios: a full pair, a dropped result, a data-space read and a
	// differential result being stored
	c_full_pair: cover property (@(posedge mclk) (sel_low && state == ADCRP_OPEN) ##[1:8] sel_high);
	c_drop: cover property (@(posedge mclk) state == ADCRP_HELD && conv.done);
	c_data_space: cover property (@(posedge mclk) sel_high && req.data_space);
	c_diff_load: cover property (@(posedge mclk) state == ADCRP_OPEN && conv.done && conv.differential);
endmodule : adcrp_top

// ===== adcrp_core_model.sv
/*
 * Core-side model: issues byte reads to the result registers.
 * Assumes the bench calls rd_byte and that requests launch at falling mclk.
 */
`timescale 1ns/10ps
module adcrp_core_model (
	// Clock
	input wire logic mclk,
	// Read request to the block
	output adcrp_pkg::adcrp_req_s req
);
	import adcrp_pkg::*;
	// Quiet bus at time zero
	initial begin
		req = '0;
	end
	// One-cycle strobe; idle bus shows the inverted address, never a stale copy
	task automatic rd_byte(input logic [7:0] a, input logic ds);
		@(negedge mclk);
		req = '{rd: 1'b1, data_space: ds, addr: a};
		@(negedge mclk);
		req = '{rd: 1'b0, data_space: ~ds, addr: ~a};
	endtask : rd_byte
endmodule : adcrp_core_model

// ===== tb_adcrp_top.sv
/*
 * Self-checking bench for the result registers and prescaler.
 * Assumes the core model drives req; the bench drives the converter side.
 */
`timescale 1ns/10ps
module tb_adcrp_top;
	import adcrp_pkg::*;
	logic mclk, rst, las, result_held, rvalid, conv_clk;
	logic [2:0] cds;
	logic [7:0] rdata;
	logic [9:0] s;
	adcrp_req_s req;
	adcrp_conv_s conv;
	logic [7:0] exp_q[$];
	logic [15:0] lfsr = 16'h0026;
	int num_errors = 0;
	int n_checks = 0;
	int per;
	int exp_p;
	time t0;
	// Free-running 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	adcrp_top dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.left_adjust_select(las), .clock_divide_select(cds), .conv(conv), .conv_clk(conv_clk),
		.result_held(result_held));
	adcrp_core_model core (.mclk(mclk), .req(req));
	// Next state of the stimulus generator
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nxt
	// Expected byte for one alignment and one half of the pair
	function automatic logic [7:0] view(input logic [9:0] v, input logic l, input logic h);
		if (l) return h ? v[9:2] : {v[1:0], 6'h00};
		return h ? {6'h00, v[9:8]} : v[7:0];
	endfunction : view
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Note the expected byte, then let the core read
	task automatic rd(input logic [7:0] a, input logic ds, input logic [7:0] e);
		exp_q.push_back(e);
		core.rd_byte(a, ds);
	endtask : rd
	// One finished conversion; value lines scrambled once done drops
	task automatic cv(input logic [9:0] v, input logic d);
		@(negedge mclk);
		conv = '{done: 1'b1, differential: d, value: v};
		@(negedge mclk);
		conv = '{done: 1'b0, differential: ~d, value: ~v};
	endtask : cv
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : tally_and_finish
	// Answers are checked in order; a stray rvalid counts as a mismatch
	always @(negedge mclk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) check("spare rvalid", 8'h01, 8'h00);
			else check("rdata", rdata, exp_q.pop_front());
		end
	end
	// Hang guard, well past the expected run length
	initial begin
		#600000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		rst = 1'b1;
		las = 1'b0;
		cds = 3'h0;
		conv = '0;
		repeat (3) @(posedge mclk);
		@(negedge mclk) rst = 1'b0;
		// Reset contents at both address spaces, then two unmapped places
		for (int i = 0; i < 4; i++) begin
			rd(8'h04 + (i[1] ? 8'h20 : 8'h00) + {7'h00, i[0]}, i[1], ADCRP_RESET_BYTE);
		end
		rd(8'h06, 1'b0, 8'h00);
		rd(8'h04, 1'b1, 8'h00);
		$display("test reset and decode done");
		// Random results, both alignments, both spaces, signed values passed as is
		for (int k = 0; k < 6; k++) begin
			lfsr = nxt(lfsr);
			las = k[0];
			cv(lfsr[9:0], k[2]);
			rd(8'h04 + (k[1] ? 8'h20 : 8'h00), k[1], view(lfsr[9:0], las, 1'b0));
			rd(8'h05 + (k[1] ? 8'h20 : 8'h00), k[1], view(lfsr[9:0], las, 1'b1));
		end
		$display("test alignment done");
		// Held pair: a new result is dropped, an alignment switch shows at once
		lfsr = nxt(lfsr);
		s = lfsr[9:0];
		las = 1'b0;
		cv(s, 1'b0);
		rd(8'h04, 1'b0, view(s, 1'b0, 1'b0));
		check("held", {7'h00, result_held}, 8'h01);
		lfsr = nxt(lfsr);
		cv(lfsr[9:0], 1'b0);
		las = 1'b1;
		rd(8'h05, 1'b0, view(s, 1'b1, 1'b1));
		check("released", {7'h00, result_held}, 8'h00);
		rd(8'h04, 1'b0, view(s, 1'b1, 1'b0));
		rd(8'h05, 1'b0, view(s, 1'b1, 1'b1));
		// Left adjusted and eight bits enough: a lone high read leaves the pair open
		rd(8'h25, 1'b1, view(s, 1'b1, 1'b1));
		check("lone high", {7'h00, result_held}, 8'h00);
		$display("test hold done");
		// Every divide code; settle past the longest half period first
		for (int c = 0; c < 8; c++) begin
			@(negedge mclk);
			cds = c[2:0];
			repeat (300) @(negedge mclk);
			exp_p = (c < 2) ? 2 : (1 << c);
			@(posedge conv_clk);
			t0 = $time;
			@(posedge conv_clk);
			per = int'(($time - t0) / 40);
			check("conv_clk period", per[7:0], exp_p[7:0]);
		end
		$display("test prescaler done");
		repeat (4) @(negedge mclk);
		check("unanswered reads", 8'(exp_q.size()), 8'h00);
		tally_and_finish();
	end
endmodule : tb_adcrp_top
